// >>> common/t2cu_defs.svh
`ifndef T2CU_DEFS_SVH
`define T2CU_DEFS_SVH
// Summary of operation
// - Overflow sets flag bit 7 unless serial-clock mode.
// - Trigger capture or reload sets edge flag bit 6.
// - Bit 5 picks this timer as receive clock.
// - Bit 4 picks this timer as transmit clock.
// - Bit 3 enables trigger pin outside serial-clock mode.
// - Run bit 2 gates counting; otherwise hold.
// - Timer mode counts every two system clocks.
// - Counter mode counts count pin falling edges.
// - Reload mode reloads on overflow and trigger.
// - Capture mode copies counter on trigger edges.
// - Serial-clock mode ignores capture/reload select.
// - Serial-clock mode reloads on every overflow.
// - Reload/capture bytes exist and reset to zero.

// ============================================================
// Register indexes; the byte address is four times the index.
`define T2CU_IDX_CONTROL 8'hc8
`define T2CU_IDX_RELOAD_LOW 8'hca
`define T2CU_IDX_RELOAD_HIGH 8'hcb
`define T2CU_IDX_COUNT_LOW 8'hcc
`define T2CU_IDX_COUNT_HIGH 8'hcd
`define T2CU_IDX_IRQ_STATUS 8'he0
`define T2CU_IDX_IRQ_MASK 8'he1

// ============================================================
// Control register bit positions.
`define T2CU_BIT_OVERFLOW 7
`define T2CU_BIT_EXT_EDGE 6
`define T2CU_BIT_RX_SEL 5
`define T2CU_BIT_TX_SEL 4
`define T2CU_BIT_TRIG_EN 3
`define T2CU_BIT_RUN 2
`define T2CU_BIT_CT_SEL 1
`define T2CU_BIT_CAP_SEL 0

// Interrupt status and mask bit positions.
`define T2CU_IRQ_OVERFLOW 0
`define T2CU_IRQ_EXT_EDGE 1

// ============================================================
// Reset values and timing.
`define T2CU_RST_BYTE 8'h00
`define T2CU_RST_WORD 16'h0000
`define T2CU_COUNT_MAX 16'hffff
`define T2CU_PIN_IDLE 1'b1
`define T2CU_DIV_CYCLES 2
`endif

// >>> common/t2cu_pkg.sv
package t2cu_pkg;

   // ============================================================
   // Main block state.
   typedef struct packed {
      logic overflow_flag;
      logic external_edge_flag;
      logic serial_rx_clock_select;
      logic serial_tx_clock_select;
      logic trigger_pin_enable;
      logic run_control;
      logic timer_counter_select;
      logic capture_reload_select;
      logic [7:0] reload_capture_low;
      logic [7:0] reload_capture_high;
      logic [7:0] count_low_byte;
      logic [7:0] count_high_byte;
      logic [1:0] irq_status;
      logic [1:0] irq_mask;
      logic ack;
      logic [7:0] rdata;
      logic rx_tick;
      logic tx_tick;
      logic irq;
   } t2cu_state_t;

   // ============================================================
   // Pin synchroniser with falling edge detector.
   typedef struct packed {
      logic meta;
      logic sync;
      logic last;
      logic fall;
   } t2cu_sync_state_t;

   // ============================================================
   // System clock divider.
   typedef struct packed {
      logic [1:0] count;
      logic pulse;
   } t2cu_div_state_t;

endpackage

// >>> logic/t2cu_sync.sv
`timescale 1ns/100ps
`include "t2cu_defs.svh"

module t2cu_sync
   import t2cu_pkg::*;
(
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic pin_i,
   output logic fall_o
);

   t2cu_sync_state_t s_r;
   t2cu_sync_state_t s_nxt;

   // Two flops resynchronise the pin; a third remembers the last level.
   always_comb begin
      s_nxt = s_r;
      s_nxt.meta = pin_i;
      s_nxt.sync = s_r.meta;
      s_nxt.last = s_r.sync;
      s_nxt.fall = s_r.last & ~s_r.sync;
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_r <= '{`T2CU_PIN_IDLE, `T2CU_PIN_IDLE, `T2CU_PIN_IDLE, 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign fall_o = s_r.fall;

endmodule

// >>> logic/t2cu_div.sv
`timescale 1ns/100ps
`include "t2cu_defs.svh"

module t2cu_div
   import t2cu_pkg::*;
(
   input wire logic clock_i,
   input wire logic reset_n_i,
   output logic pulse_o
);

   localparam logic [1:0] LAST = 2'(`T2CU_DIV_CYCLES - 1);

   t2cu_div_state_t s_r;
   t2cu_div_state_t s_nxt;

   // One enable pulse every divider period of the system clock.
   always_comb begin
      s_nxt = s_r;
      s_nxt.pulse = (s_r.count == LAST);
      if (s_r.count == LAST) begin
         s_nxt.count = 2'h0;
      end else begin
         s_nxt.count = s_r.count + 2'h1;
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_r <= '{2'h0, 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign pulse_o = s_r.pulse;

endmodule

// >>> logic/t2cu_timer.sv
// Our own choice: register access over Wishbone.
`timescale 1ns/100ps
`include "t2cu_defs.svh"

module t2cu_timer
   import t2cu_pkg::*;
(
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic count_input_pin_i,
   input wire logic trigger_pin_i,
   input wire logic timer1_overflow_i,
   output logic serial_rx_clock_o,
   output logic serial_tx_clock_o,
   output logic irq_o
);

   // ============================================================
   // Pin conditioning and time base.
   logic count_fall;
   logic trigger_fall;
   logic div_pulse;

   t2cu_sync u_count_sync (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .pin_i(count_input_pin_i),
      .fall_o(count_fall)
   );

   t2cu_sync u_trigger_sync (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .pin_i(trigger_pin_i),
      .fall_o(trigger_fall)
   );

   t2cu_div u_div (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .pulse_o(div_pulse)
   );

   // ============================================================
   // State.
   t2cu_state_t s_r;
   t2cu_state_t s_nxt;

   logic hit;
   logic wr;
   logic [7:0] idx;
   logic [7:0] wd;
   logic baud_mode;
   logic tick;
   logic overflow;
   logic trigger;
   logic reload_on_overflow;
   logic [15:0] count;
   logic [15:0] reload;
   logic [15:0] count_inc;
   logic [7:0] control_rd;

   assign count = {s_r.count_high_byte, s_r.count_low_byte};
   assign reload = {s_r.reload_capture_high, s_r.reload_capture_low};
   assign count_inc = count + 16'h0001;

   always_comb begin
      control_rd = `T2CU_RST_BYTE;
      control_rd[`T2CU_BIT_OVERFLOW] = s_r.overflow_flag;
      control_rd[`T2CU_BIT_EXT_EDGE] = s_r.external_edge_flag;
      control_rd[`T2CU_BIT_RX_SEL] = s_r.serial_rx_clock_select;
      control_rd[`T2CU_BIT_TX_SEL] = s_r.serial_tx_clock_select;
      control_rd[`T2CU_BIT_TRIG_EN] = s_r.trigger_pin_enable;
      control_rd[`T2CU_BIT_RUN] = s_r.run_control;
      control_rd[`T2CU_BIT_CT_SEL] = s_r.timer_counter_select;
      control_rd[`T2CU_BIT_CAP_SEL] = s_r.capture_reload_select;
   end

   // ============================================================
   // Next-state logic.
   always_comb begin
      s_nxt = s_r;

      // Classic Wishbone slave: one wait state, ack for one cycle.
      hit = wb_cyc_i & wb_stb_i & ~s_r.ack;
      wr = hit & wb_we_i & wb_sel_i[0];
      idx = wb_adr_i[9:2];
      wd = wb_dat_i[7:0];
      s_nxt.ack = hit;

      baud_mode = s_r.serial_rx_clock_select | s_r.serial_tx_clock_select;
      tick = s_r.run_control &
         (s_r.timer_counter_select ? count_fall : div_pulse);
      overflow = tick & (count == `T2CU_COUNT_MAX);
      trigger = trigger_fall & s_r.trigger_pin_enable & ~baud_mode;
      reload_on_overflow = baud_mode | ~s_r.capture_reload_select;

      // Counter advance, wrap and reload.
      if (tick) begin
         s_nxt.count_low_byte = count_inc[7:0];
         s_nxt.count_high_byte = count_inc[15:8];
      end
      if (overflow && reload_on_overflow) begin
         s_nxt.count_low_byte = s_r.reload_capture_low;
         s_nxt.count_high_byte = s_r.reload_capture_high;
      end
      if (trigger && !s_r.capture_reload_select) begin
         s_nxt.count_low_byte = reload[7:0];
         s_nxt.count_high_byte = reload[15:8];
      end

      // Register writes; a counter write wins over counting.
      if (wr) begin
         case (idx)
            `T2CU_IDX_CONTROL: begin
               s_nxt.overflow_flag = wd[`T2CU_BIT_OVERFLOW];
               s_nxt.external_edge_flag = wd[`T2CU_BIT_EXT_EDGE];
               s_nxt.serial_rx_clock_select = wd[`T2CU_BIT_RX_SEL];
               s_nxt.serial_tx_clock_select = wd[`T2CU_BIT_TX_SEL];
               s_nxt.trigger_pin_enable = wd[`T2CU_BIT_TRIG_EN];
               s_nxt.run_control = wd[`T2CU_BIT_RUN];
               s_nxt.timer_counter_select = wd[`T2CU_BIT_CT_SEL];
               s_nxt.capture_reload_select = wd[`T2CU_BIT_CAP_SEL];
            end
            `T2CU_IDX_RELOAD_LOW: begin
               s_nxt.reload_capture_low = wd;
            end
            `T2CU_IDX_RELOAD_HIGH: begin
               s_nxt.reload_capture_high = wd;
            end
            `T2CU_IDX_COUNT_LOW: begin
               s_nxt.count_low_byte = wd;
            end
            `T2CU_IDX_COUNT_HIGH: begin
               s_nxt.count_high_byte = wd;
            end
            `T2CU_IDX_IRQ_STATUS: begin
               s_nxt.irq_status = s_r.irq_status & ~wd[1:0];
            end
            `T2CU_IDX_IRQ_MASK: begin
               s_nxt.irq_mask = wd[1:0];
            end
            default: begin
            end
         endcase
      end

      // Capture copies both bytes in the same edge, over a write.
      if (trigger && s_r.capture_reload_select) begin
         s_nxt.reload_capture_low = count[7:0];
         s_nxt.reload_capture_high = count[15:8];
      end

      // Hardware flag sets win over a clear in the same cycle.
      if (overflow && !baud_mode) begin
         s_nxt.overflow_flag = 1'b1;
         s_nxt.irq_status[`T2CU_IRQ_OVERFLOW] = 1'b1;
      end
      if (trigger) begin
         s_nxt.external_edge_flag = 1'b1;
         s_nxt.irq_status[`T2CU_IRQ_EXT_EDGE] = 1'b1;
      end

      // Serial port baud clocks.
      s_nxt.rx_tick = s_r.serial_rx_clock_select ? overflow :
         timer1_overflow_i;
      s_nxt.tx_tick = s_r.serial_tx_clock_select ? overflow :
         timer1_overflow_i;

      s_nxt.irq = |(s_nxt.irq_status & s_nxt.irq_mask);

      // Read data shows the value held before this access.
      s_nxt.rdata = `T2CU_RST_BYTE;
      if (hit && !wb_we_i) begin
         case (idx)
            `T2CU_IDX_CONTROL: begin
               s_nxt.rdata = control_rd;
            end
            `T2CU_IDX_RELOAD_LOW: begin
               s_nxt.rdata = s_r.reload_capture_low;
            end
            `T2CU_IDX_RELOAD_HIGH: begin
               s_nxt.rdata = s_r.reload_capture_high;
            end
            `T2CU_IDX_COUNT_LOW: begin
               s_nxt.rdata = s_r.count_low_byte;
            end
            `T2CU_IDX_COUNT_HIGH: begin
               s_nxt.rdata = s_r.count_high_byte;
            end
            `T2CU_IDX_IRQ_STATUS: begin
               s_nxt.rdata = {6'h00, s_r.irq_status};
            end
            `T2CU_IDX_IRQ_MASK: begin
               s_nxt.rdata = {6'h00, s_r.irq_mask};
            end
            default: begin
               s_nxt.rdata = `T2CU_RST_BYTE;
            end
         endcase
      end
   end

   // ============================================================
   // State register.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_r <= '0;
         s_r.reload_capture_low <= `T2CU_RST_BYTE;
         s_r.reload_capture_high <= `T2CU_RST_BYTE;
         s_r.count_low_byte <= `T2CU_RST_BYTE;
         s_r.count_high_byte <= `T2CU_RST_BYTE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ============================================================
   // Outputs.
   assign wb_ack_o = s_r.ack;
   assign wb_dat_o = {24'h000000, s_r.rdata};
   assign serial_rx_clock_o = s_r.rx_tick;
   assign serial_tx_clock_o = s_r.tx_tick;
   assign irq_o = s_r.irq;

endmodule

// >>> tb/t2cu_monitor.sv
`timescale 1ns/100ps
module t2cu_monitor (
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic timer1_overflow_i,
   input wire logic serial_rx_clock_o,
   input wire logic serial_tx_clock_o,
   input wire logic irq_o
);
   logic [5:0] ctl_r;
   logic [1:0] mask_r;
   logic wr_take;
   assign wr_take = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
      wb_sel_i[0];
   // Software-only control and mask bits are mirrored from bus writes.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctl_r <= 6'h00;
         mask_r <= 2'h0;
      end else if (wr_take && wb_adr_i[9:2] == 8'hc8) begin
         ctl_r <= wb_dat_i[5:0];
      end else if (wr_take && wb_adr_i[9:2] == 8'he1) begin
         mask_r <= wb_dat_i[1:0];
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_answer; wb_ack_o ##1 !wb_ack_o; endsequence
   property p_ack; s_take |=> s_answer; endproperty
   property p_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
   property p_upper; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
   property p_ctl_rd;
      wb_ack_o && !wb_we_i && wb_adr_i[9:2] == 8'hc8 |->
         wb_dat_o[5:0] == ctl_r;
   endproperty
   property p_mask_rd;
      wb_ack_o && !wb_we_i && wb_adr_i[9:2] == 8'he1 |->
         wb_dat_o[1:0] == mask_r;
   endproperty
   property p_rx;
      !ctl_r[5] && !$past(ctl_r[5]) |->
         serial_rx_clock_o == $past(timer1_overflow_i);
   endproperty
   property p_tx;
      !ctl_r[4] && !$past(ctl_r[4]) |->
         serial_tx_clock_o == $past(timer1_overflow_i);
   endproperty
   property p_irq; mask_r == 2'h0 && $past(mask_r) == 2'h0 |-> !irq_o; endproperty
   a_ack: assert property (p_ack) else $error("ack missing or too long");
   a_idle: assert property (p_idle) else $error("read data outside ack");
   a_upper: assert property (p_upper) else $error("read data upper bits set");
   a_ctl_rd: assert property (p_ctl_rd) else $error("control readback");
   a_mask_rd: assert property (p_mask_rd) else $error("mask readback");
   a_rx: assert property (p_rx) else $error("rx clock not timer1");
   a_tx: assert property (p_tx) else $error("tx clock not timer1");
   a_irq: assert property (p_irq) else $error("irq while masked");
endmodule
bind t2cu_timer t2cu_monitor mon_u (.clock_i(clock_i), .reset_n_i(reset_n_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
   .timer1_overflow_i(timer1_overflow_i),
   .serial_rx_clock_o(serial_rx_clock_o),
   .serial_tx_clock_o(serial_tx_clock_o));

// >>> tb/t2cu_far.sv
`timescale 1ns/100ps
module t2cu_far (
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic rx_i,
   input wire logic tx_i,
   output logic count_pin_o = 1'b1,
   output logic trigger_pin_o = 1'b1,
   output logic t1_ovf_o = 1'b0
);
   int rx_seen = 0;
   int tx_seen = 0;
   always @(posedge clock_i) begin
      rx_seen <= rx_seen + int'(rx_i === 1'b1);
      tx_seen <= tx_seen + int'(tx_i === 1'b1);
   end
   // Low is held three cycles and high at least four, so the pin sampler sees every edge.
   task automatic fall_pin(input bit trig, input int n);
      repeat (n) begin
         @(posedge clock_i);
         if (trig) trigger_pin_o <= 1'b0;
         else count_pin_o <= 1'b0;
         repeat (3) @(posedge clock_i);
         trigger_pin_o <= 1'b1;
         count_pin_o <= 1'b1;
         repeat (3) @(posedge clock_i);
      end
   endtask
   task automatic t1_pulses(input int n);
      repeat (n) begin
         @(posedge clock_i);
         t1_ovf_o <= 1'b1;
         @(posedge clock_i);
         t1_ovf_o <= 1'b0;
      end
   endtask
endmodule

// >>> tb/tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin \
   cmp_count++; \
   if ((g) !== (e)) begin \
      num_errors++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
   end \
end
module tb;
   logic clock_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [9:0] adr = 10'h000;
   logic [31:0] dw = 32'h0;
   logic [3:0] sel = 4'h0;
   logic [31:0] dr;
   logic ack, rx, tx, irq, cp, tp, t1;
   int num_errors = 0;
   int cmp_count = 0;
   int n0, n1, k;
   logic [7:0] v;
   logic [15:0] w;
   logic [7:0] regs [8] = '{8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'he0,
      8'he1, 8'h10};
   always #25 clock_i = ~clock_i;
   t2cu_timer dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .count_input_pin_i(cp),
      .trigger_pin_i(tp), .timer1_overflow_i(t1), .serial_rx_clock_o(rx),
      .serial_tx_clock_o(tx), .irq_o(irq));
   t2cu_far far_u (.clock_i(clock_i), .reset_n_i(reset_n_i), .rx_i(rx),
      .tx_i(tx), .count_pin_o(cp), .trigger_pin_o(tp), .t1_ovf_o(t1));
   task automatic bus(input logic w_en, input logic [7:0] a,
      input logic [7:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      sel <= 4'h1;
      we <= w_en;
      adr <= {a, 2'b00};
      dw <= {24'h0, d};
      do @(posedge clock_i); while (ack !== 1'b1 && ++n < 50);
      if (n >= 50) num_errors++;
      v = dr[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      sel <= 4'h0;
      @(posedge clock_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      `CHK(v, e)
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      num_errors++;
      complete_run();
   end
   initial begin
      repeat (5) @(posedge clock_i);
      reset_n_i <= 1'b1;
      @(posedge clock_i);
      w = 16'($urandom(58));
      foreach (regs[i]) expect_reg(regs[i], 8'h00);
      $display("test reset values done");
      wr(8'hcc, 8'h00);
      wr(8'hcd, 8'h00);
      wr(8'hc8, 8'h04);
      repeat (40) @(posedge clock_i);
      wr(8'hc8, 8'h00);
      bus(1'b0, 8'hcc, 8'h00);
      `CHK(v >= 8'h14 && v <= 8'h17, 1'b1)
      repeat (20) @(posedge clock_i);
      expect_reg(8'hcc, v);
      expect_reg(8'hcd, 8'h00);
      $display("test timer rate done");
      w = 16'($urandom) & 16'hff7f;
      wr(8'hca, w[7:0]);
      wr(8'hcb, w[15:8]);
      wr(8'hcc, 8'hfc);
      wr(8'hcd, 8'hff);
      wr(8'he1, 8'h01);
      wr(8'hc8, 8'h04);
      repeat (30) @(posedge clock_i);
      `CHK(irq, 1'b1)
      expect_reg(8'hc8, 8'h84);
      wr(8'hc8, 8'h80);
      expect_reg(8'hcd, w[15:8]);
      expect_reg(8'he0, 8'h01);
      wr(8'hc8, 8'h00);
      expect_reg(8'hc8, 8'h00);
      wr(8'he0, 8'h01);
      expect_reg(8'he0, 8'h00);
      `CHK(irq, 1'b0)
      $display("test overflow reload done");
      w = 16'($urandom);
      wr(8'hcc, w[7:0]);
      wr(8'hcd, w[15:8]);
      wr(8'hc8, 8'h01);
      far_u.fall_pin(1'b1, 1);
      expect_reg(8'hc8, 8'h01);
      wr(8'hc8, 8'h09);
      far_u.fall_pin(1'b1, 1);
      expect_reg(8'hca, w[7:0]);
      expect_reg(8'hcb, w[15:8]);
      expect_reg(8'hc8, 8'h49);
      `CHK(irq, 1'b0)
      wr(8'hc8, 8'h39);
      far_u.fall_pin(1'b1, 1);
      expect_reg(8'hc8, 8'h39);
      wr(8'he0, 8'h02);
      wr(8'he1, 8'h02);
      `CHK(irq, 1'b0)
      wr(8'hc8, 8'h08);
      wr(8'hcc, 8'h00);
      wr(8'hcd, 8'h00);
      far_u.fall_pin(1'b1, 1);
      expect_reg(8'hcc, w[7:0]);
      expect_reg(8'hc8, 8'h48);
      `CHK(irq, 1'b1)
      $display("test trigger pin done");
      wr(8'hcc, 8'h00);
      wr(8'hc8, 8'h06);
      k = 3 + $urandom % 5;
      far_u.fall_pin(1'b0, k);
      wr(8'hc8, 8'h00);
      expect_reg(8'hcc, 8'(k));
      $display("test counter mode done");
      n0 = far_u.rx_seen;
      n1 = far_u.tx_seen;
      far_u.t1_pulses(5);
      repeat (3) @(posedge clock_i);
      `CHK(far_u.rx_seen - n0, 5)
      `CHK(far_u.tx_seen - n1, 5)
      wr(8'hca, 8'hf0);
      wr(8'hcb, 8'hff);
      wr(8'hcc, 8'hf0);
      wr(8'hcd, 8'hff);
      n0 = far_u.rx_seen;
      n1 = far_u.tx_seen;
      wr(8'hc8, 8'h14);
      repeat (200) @(posedge clock_i);
      expect_reg(8'hc8, 8'h14);
      wr(8'hc8, 8'h10);
      expect_reg(8'hcd, 8'hff);
      `CHK(far_u.rx_seen - n0, 0)
      n1 = far_u.tx_seen - n1;
      `CHK(n1 >= 5 && n1 <= 7, 1'b1)
      n0 = far_u.rx_seen;
      n1 = far_u.tx_seen;
      wr(8'hc8, 8'h24);
      repeat (200) @(posedge clock_i);
      wr(8'hc8, 8'h20);
      n0 = far_u.rx_seen - n0;
      `CHK(n0 >= 5 && n0 <= 7, 1'b1)
      `CHK(far_u.tx_seen - n1, 0)
      $display("test serial clock done");
      reset_n_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      reset_n_i <= 1'b1;
      @(posedge clock_i);
      `CHK(irq, 1'b0)
      expect_reg(8'hca, 8'h00);
      expect_reg(8'hc8, 8'h00);
      $display("test mid-run reset done");
      complete_run();
   end
endmodule
